/* bench/dsr_core_checker.sv */
/* Assertions on the ports of dsr_core, attached by bind.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module dsr_core_checker
  import dsr_pkg::*;
#(parameter int T_CKE = 5, parameter int T_RFC = 11, parameter int ROW_W = 14) (
  input wire logic             clk,
  input wire logic             nrst,
  input wire dsr_cmd_t         cmd,
  input wire logic             in_self_refresh,
  input wire logic             refresh_busy,
  input wire logic             refresh_strobe,
  input wire logic [ROW_W-1:0] refresh_row,
  input wire logic             dll_enable,
  input wire logic             dll_reset,
  input wire logic             dll_locked,
  input wire logic             banks_precharged,
  input wire logic             termination_on
);
  // ------------------------------------------------------------
  // Helper counters, reset like the device so first edges agree
  // ------------------------------------------------------------
  logic       ck_q;
  logic       ref_c;
  logic [7:0] gap_q;
  logic [7:0] since_q;
  assign ref_c = !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && cmd.we_n;
  always_ff @(posedge clk) begin
    ck_q    <= nrst & cmd.cke;
    gap_q   <= (!nrst || !in_self_refresh || refresh_strobe) ? 8'h00 : gap_q + 8'h01;
    since_q <= (!nrst || refresh_strobe) ? 8'h01 : since_q + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_sr_entry: assert property (ck_q && !cmd.cke && ref_c |=>
    in_self_refresh && !dll_enable) else $error("self refresh entry missed");
  chk_ref_take: assert property (!in_self_refresh && ck_q && cmd.cke && ref_c |=>
    refresh_strobe && refresh_busy && refresh_row == $past(refresh_row) + 1'b1)
    else $error("refresh command missed");
  chk_sr_exit: assert property (in_self_refresh && cmd.cke |=>
    !in_self_refresh && dll_enable && dll_reset && !dll_locked) else $error("exit wrong");
  chk_sr_hold: assert property (in_self_refresh && !cmd.cke |=>
    in_self_refresh && !dll_enable && !termination_on) else $error("pins heeded in sr");
  chk_sr_timer: assert property (gap_q <= T_CKE) else $error("no internal refresh");
  chk_busy_len: assert property ($fell(refresh_busy) |-> since_q == T_RFC + 1)
    else $error("busy length wrong");
  chk_banks_idle: assert property (banks_precharged == !refresh_busy)
    else $error("banks state wrong");
  chk_row_step: assert property ($changed(refresh_row) |-> refresh_strobe)
    else $error("row moved without refresh");
endmodule // dsr_core_checker
bind dsr_core dsr_core_checker #(.T_CKE(T_CKE), .T_RFC(T_RFC), .ROW_W(ROW_W)) u_chk (
  .clk(clk), .nrst(nrst), .cmd(cmd), .in_self_refresh(in_self_refresh),
  .refresh_busy(refresh_busy), .refresh_strobe(refresh_strobe), .refresh_row(refresh_row),
  .dll_enable(dll_enable), .dll_reset(dll_reset), .dll_locked(dll_locked),
  .banks_precharged(banks_precharged), .termination_on(termination_on));
`default_nettype wire

/* bench/dsr_core_tb.sv */
/* Self-checking bench for dsr_core with the controller model.
   Assumes default timing except a short DLL relock count. */
`timescale 1ns/100ps
`default_nettype none
module dsr_core_tb;
  import dsr_pkg::*;
  typedef struct packed { logic [1:0] op; logic t; logic [4:0] e; } dsr_row_t;
  logic                  clk  = 1'b0;
  logic                  nrst = 1'b0;
  logic                  term = 1'b0;
  logic [1:0]            op   = 2'd0;
  dsr_cmd_t              cmd;
  logic                  in_sr, busy, strb, den, drst, lock, bpre, ton;
  logic [ROW_ADDR_W-1:0] row, exp_row;
  int                    error_cnt = 0, n_checks = 0, b, i;
  dsr_row_t rows [4] = '{'{2'd0, 1'b1, 5'b00110}, '{2'd0, 1'b0, 5'b00010},
                         '{2'd1, 1'b0, 5'b01010}, '{2'd1, 1'b0, 5'b01010}};
  always #5 clk = ~clk;
  dsr_ctl_model u_ctl (.clk(clk), .op(op), .cmd(cmd));
  dsr_core #(.T_DLLK(8)) DUT (.clk(clk), .nrst(nrst), .cmd(cmd),
    .termination_control_pin(term), .in_self_refresh(in_sr), .refresh_busy(busy),
    .refresh_strobe(strb), .refresh_row(row), .dll_enable(den), .dll_reset(drst),
    .dll_locked(lock), .banks_precharged(bpre), .termination_on(ton));
  task automatic chk(input string nm, input logic [23:0] s, e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic step(input logic [1:0] o, input logic t);
    op = o;
    term = t;
    @(negedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    exp_row = '0;
    repeat (8) @(negedge clk);
    chk("reset", {in_sr, strb, ton, den, drst, bpre, lock, row}, 21'h028000);
    $display("reset done");
    nrst = 1'b1;
    step(2'd0, 1'b0);
    foreach (rows[k]) begin
      step(rows[k].op, rows[k].t);
      exp_row += (rows[k].op == 2'd1);
      chk("state", {in_sr, strb, ton, den, drst}, rows[k].e);
      chk("row", row, exp_row);
      chk("banks", bpre, rows[k].op != 2'd1);
      b = 0;
      // Only idle commands while busy; banks idle beforehand
      repeat (13 * rows[k].op) begin
        step(2'd0, 1'b0);
        b += busy;
      end
      if (rows[k].op == 2'd1) chk("busy", b, T_RFC_CYC);
      $display("row %0d done", k);
    end
    // Banks idle, termination low, nothing deferred
    // Two refreshes at rate, refresh debt stays at zero
    // Clock never stops; no re-entry after exit is tried
    step(2'd2, 1'b0);
    chk("entry", {in_sr, den}, 2'b10);
    b = 0;
    repeat (3 * T_CKE_CYC) begin
      step(2'd0, 1'b1);
      b += strb;
    end
    chk("sr term", ton, 1'b0);
    chk("sr strobes", b >= 2, 1'b1);
    chk("sr row", row, exp_row + b[ROW_ADDR_W-1:0]);
    step(2'd3, 1'b0);
    chk("exit", {in_sr, den, drst, lock}, 4'b0110);
    i = 0;
    while (lock !== 1'b1 && i < 64) begin
      step(2'd0, 1'b0);
      i++;
    end
    if (i == 64) begin
      error_cnt++;
      end_sim();
    end
    repeat (12) step(2'd0, 1'b1);
    chk("relocked", {den, ton}, 2'b11);
    $display("self refresh done");
    nrst = 1'b0;
    step(2'd0, 1'b0);
    step(2'd0, 1'b0);
    chk("rereset", {in_sr, strb, ton, den, drst, bpre, lock, row}, 21'h028000);
    nrst = 1'b1;
    step(2'd0, 1'b0);
    $display("second reset done");
    end_sim();
  end
endmodule // dsr_core_tb
`default_nettype wire

/* bench/dsr_ctl_model.sv */
/* Controller command driver: op 0 idle, 1 refresh, 2 entry, 3 exit.
   Assumes the bench changes op on the falling edge. */
`timescale 1ns/100ps
`default_nettype none
module dsr_ctl_model
  import dsr_pkg::*;
(
  input  wire logic [1:0] op,
  input  wire logic       clk,
  output var dsr_cmd_t    cmd
);
  logic sr_q = 1'b0;
  logic tg_q = 1'b0;
  always @(posedge clk) begin
    tg_q <= ~tg_q;
    if (op[1])
      sr_q <= ~op[0];
  end
  // Idle and don't-care pins toggle so stale levels cannot pass
  always_comb begin
    cmd = '{1'b1, 1'b1, tg_q, ~tg_q, tg_q};
    if (op == 2'd1)
      cmd = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    if (op == 2'd2)
      cmd = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    if (sr_q && op != 2'd3)
      cmd = '{1'b0, tg_q, tg_q, tg_q, ~tg_q};
  end
endmodule // dsr_ctl_model
`default_nettype wire

/* rtl/dsr_core.sv */
/*
  Device-side refresh and self-refresh logic of a DDR3 DRAM: decodes
  refresh and self-refresh commands, runs the internal row counter,
  drives the DLL enable and the internal self-refresh timer.
  Assumes the controller keeps its own timing rules; pins are
  synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Self-refresh entry: CS, RAS, CAS, CKE low, WE high at edge.
// - DLL off on self-refresh entry; on exit re-enabled with reset.
// - In self-refresh only CKE and reset pin are heeded.
// - At least one internal refresh within tCKE after entry.
// - Refresh: CS, RAS, CAS low, WE high, CKE high; reissued each time.
// - Rows from internal counter, address ignored, banks left precharged.
module dsr_core
  import dsr_pkg::*;
#(
  parameter int T_CKE    = T_CKE_CYC,
  parameter int T_RFC    = T_RFC_CYC,
  parameter int T_DLLK   = T_DLLK_CYC,
  parameter int ROW_W    = ROW_ADDR_W
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire dsr_cmd_t         cmd,
  input  wire logic             termination_control_pin,
  output logic                  in_self_refresh,
  output logic                  refresh_busy,
  output logic                  refresh_strobe,
  output logic [ROW_W-1:0]      refresh_row,
  output logic                  dll_enable,
  output logic                  dll_reset,
  output logic                  dll_locked,
  output logic                  banks_precharged,
  output logic                  termination_on
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {DSR_IDLE, DSR_SELF, DSR_RELOCK} dsr_state_t;

  dsr_state_t            st_q, st_d;
  logic                  cke_q;
  logic [ROW_W-1:0]      row_q, row_d;
  logic [CNT_W-1:0]      sr_tmr_q, sr_tmr_d;
  logic                  strobe_q, strobe_d;
  logic                  dll_rst_q, dll_rst_d;
  logic                  term_q, term_d;
  dsr_cmd_kind_t         kind;
  logic                  rfc_load, rfc_busy, dll_load, dll_busy;

  // Entry is decided with CKE low, so the previous CKE is kept
  assign kind = dsr_decode(cmd, cke_q);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    row_d     = row_q;
    sr_tmr_d  = sr_tmr_q;
    strobe_d  = 1'b0;
    dll_rst_d = 1'b0;
    term_d    = 1'b0;
    rfc_load  = 1'b0;
    dll_load  = 1'b0;
    case (st_q)
      DSR_IDLE, DSR_RELOCK: begin
        if (st_q == DSR_RELOCK && !dll_busy)
          st_d = DSR_IDLE;
        if (kind == DSR_CMD_REFRESH) begin
          // Address pins not looked at: row comes from the counter
          strobe_d = 1'b1;
          row_d    = row_q + ROW_W'(1);
          rfc_load = 1'b1;
        end else if (kind == DSR_CMD_SR_ENTRY) begin
          st_d     = DSR_SELF;
          // First internal refresh lands T_CKE cycles after entry, right at tCKE
          sr_tmr_d = CNT_W'(T_CKE - 1);
        end
        // Termination follows the pin only with the DLL locked
        term_d = termination_control_pin && st_q == DSR_IDLE;
      end
      DSR_SELF: begin
        // Every pin but CKE ignored here
        if (sr_tmr_q == '0) begin
          strobe_d = 1'b1;
          row_d    = row_q + ROW_W'(1);
          rfc_load = 1'b1;
          sr_tmr_d = CNT_W'(T_CKE - 1);
        end else begin
          sr_tmr_d = sr_tmr_q - CNT_W'(1);
        end
        if (cmd.cke) begin
          st_d      = DSR_RELOCK;
          dll_rst_d = 1'b1;
          dll_load  = 1'b1;
        end
      end
      default: st_d = DSR_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q      <= DSR_IDLE;
      cke_q     <= 1'b0;
      row_q     <= '0;
      sr_tmr_q  <= '0;
      strobe_q  <= 1'b0;
      dll_rst_q <= 1'b0;
      term_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      cke_q     <= cmd.cke;
      row_q     <= row_d;
      sr_tmr_q  <= sr_tmr_d;
      strobe_q  <= strobe_d;
      dll_rst_q <= dll_rst_d;
      term_q    <= term_d;
    end
  end

  dsr_count #(.W(CNT_W)) u_rfc (
    .clk   (clk),
    .nrst  (nrst),
    .load  (rfc_load),
    .value (CNT_W'(T_RFC)),
    .busy  (rfc_busy)
  );

  dsr_count #(.W(CNT_W)) u_dll (
    .clk   (clk),
    .nrst  (nrst),
    .load  (dll_load),
    .value (CNT_W'(T_DLLK)),
    .busy  (dll_busy)
  );

  // ---------------------------------------------------------------
  // Outputs, all from flip-flops
  // ---------------------------------------------------------------
  logic busy_q, lock_q, sr_q, pre_q, dll_en_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_q   <= 1'b0;
      lock_q   <= 1'b0;
      sr_q     <= 1'b0;
      pre_q    <= 1'b1;
      dll_en_q <= 1'b1;
    end else begin
      busy_q   <= rfc_busy | rfc_load;
      lock_q   <= st_d == DSR_IDLE;
      sr_q     <= st_d == DSR_SELF;
      pre_q    <= !(rfc_busy | rfc_load);
      dll_en_q <= st_d != DSR_SELF;
    end
  end

  assign in_self_refresh  = sr_q;
  assign refresh_busy     = busy_q;
  assign refresh_strobe   = strobe_q;
  assign refresh_row      = row_q;
  assign dll_enable       = dll_en_q;
  assign dll_reset        = dll_rst_q;
  assign dll_locked       = lock_q;
  assign banks_precharged = pre_q;
  assign termination_on   = term_q;

endmodule // dsr_core
`default_nettype wire

/* rtl/dsr_count.sv */
/*
  Down counter with load, used for refresh busy time and DLL relock.
  Assumes load is synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module dsr_count #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              busy
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load)
      cnt_d = value;
    else if (cnt_q != '0)
      cnt_d = cnt_q - W'(1);
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign busy = (cnt_q != '0);
endmodule // dsr_count
`default_nettype wire

/* rtl/dsr_pkg.sv */
/*
  Package for the DRAM refresh / self-refresh device model: command
  encodings, timing counts and the carrier struct for the command pins.
  Assumes a single 100 MHz clock shared with the controller side.
*/
package dsr_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int T_CKE_NS       = 50;
  localparam int T_CKE_CYC      = (T_CKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RFC_NS       = 110;
  localparam int T_RFC_CYC      = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_DLLK_CYC     = 512;
  localparam int ROW_ADDR_W     = 14;
  localparam int CNT_W          = 12;

  // ---------------------------------------------------------------
  // Command pins, all active low except cke
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dsr_cmd_t;

  typedef enum logic [1:0] {
    DSR_CMD_NONE,
    DSR_CMD_REFRESH,
    DSR_CMD_SR_ENTRY,
    DSR_CMD_SR_EXIT
  } dsr_cmd_kind_t;

  // Decode against previous cke; cke low at edge with CS/RAS/CAS low means entry
  function automatic dsr_cmd_kind_t dsr_decode(input dsr_cmd_t c, input logic cke_prev);
    logic nop;
    nop = c.cs_n | (c.ras_n & c.cas_n & c.we_n);
    if (cke_prev && !c.cke && !c.cs_n && !c.ras_n && !c.cas_n && c.we_n)
      return DSR_CMD_SR_ENTRY;
    else if (cke_prev && c.cke && !c.cs_n && !c.ras_n && !c.cas_n && c.we_n)
      return DSR_CMD_REFRESH;
    else if (!cke_prev && c.cke && nop)
      return DSR_CMD_SR_EXIT;
    else
      return DSR_CMD_NONE;
  endfunction

endpackage
